// ==== rtl/flic_top.v ====
// Function
// [RQ1] five levels 4..0; power-fail fixed at 4, others programmable 3..0
// [RQ2] each source vectors to its fixed address
// [RQ3] fixed natural order 0..12, power-fail first, watchdog last
// [RQ4] flags set regardless of enable; flag alone causes no interrupt
// [RQ5] timer 0/1 overflow flags cleared on vectoring
// [RQ6] edge-mode ext 0/1 flags cleared on vectoring; level mode tracks pin
// [RQ7] all other flags stay set until software clears them
// [RQ8] non power-fail sources need own enable and global enable
// [RQ9] power-fail gated only by its own enable
// [RQ10] level stays in service until return from interrupt
// [RQ11] preemption only by strictly higher level
// [RQ12] sample and arbitrate only in final memory cycle of instruction
// [RQ13] ext 0/1 active low; level mode requests while pin low
// [RQ14] edge mode sets flag on high then low successive samples
// [RQ15] far side holds each pin level at least two clocks
// [RQ16] level requests not latched; source must hold until serviced
// [RQ17] ext 2..5 edge only; 2,4 rising, 3,5 falling
// [RQ18] ext 2..5 flag means edge seen, not pin state
// [RQ19] power management samples edges every 1024 clocks
// [RQ20] equal level ties resolved by natural order
// [RQ21] forced call in cycle after selection unless blocked
// [RQ22] selection skipped after enable or priority register write
// [RQ23] hardware update beats simultaneous software write
// [RQ24] level from two priority bits, upper bit more significant
// [RQ25] dual-flag sources request while either flag set
`timescale 1ns/100ps
`include "flic_defines.vh"
module flic_top (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        ext_pin_zero,
  input  wire        ext_pin_one,
  input  wire        ext_pin_two,
  input  wire        ext_pin_three,
  input  wire        ext_pin_four,
  input  wire        ext_pin_five,
  input  wire        pwrFailWarn,
  input  wire        timerZeroOvf,
  input  wire        timerOneOvf,
  input  wire        timer_two_overflow_flag,
  input  wire        timer_two_external_flag,
  input  wire        serial_zero_rx_flag,
  input  wire        serial_zero_tx_flag,
  input  wire        serial_one_rx_flag,
  input  wire        serial_one_tx_flag,
  input  wire        watchdogIrqEvt,
  input  wire        lastCycle,
  input  wire        return_from_isr,
  output reg         irqCall,
  output reg  [7:0]  irqVector,
  output reg  [4:0]  inService
);

  integer i;

  // =====================================================
  // decode helpers
  function [2:0] prioLevel;
    input hiBit;
    input loBit;
    begin
      prioLevel = {1'b0, hiBit, loBit}; // RQ24
    end
  endfunction

  function [7:0] vecOf;
    input [3:0] idx;
    begin
      case (idx) // RQ2
        4'd0:    vecOf = `FLIC_VEC_PF;
        4'd1:    vecOf = `FLIC_VEC_EXT0;
        4'd2:    vecOf = `FLIC_VEC_TMR0;
        4'd3:    vecOf = `FLIC_VEC_EXT1;
        4'd4:    vecOf = `FLIC_VEC_TMR1;
        4'd5:    vecOf = `FLIC_VEC_SER0;
        4'd6:    vecOf = `FLIC_VEC_TMR2;
        4'd7:    vecOf = `FLIC_VEC_SER1;
        4'd8:    vecOf = `FLIC_VEC_EXT2;
        4'd9:    vecOf = `FLIC_VEC_EXT3;
        4'd10:   vecOf = `FLIC_VEC_EXT4;
        4'd11:   vecOf = `FLIC_VEC_EXT5;
        default: vecOf = `FLIC_VEC_WDOG;
      endcase
    end
  endfunction

  // =====================================================
  // registers
  reg [7:0] tctrl_q;
  reg [7:0] ien_q;
  reg [7:0] prioLo_q;
  reg [7:0] prioHi_q;
  reg [7:0] xflag_q;
  reg [7:0] xen_q;
  reg [7:0] xprioLo_q;
  reg [7:0] xprioHi_q;
  reg [7:0] wdctrl_q;
  reg [7:0] ctrl_q;
  reg       skipSel_q;
  reg [9:0] divCnt_q;
  reg       sampleEn_q;

  reg [7:0] tctrl_d;
  reg [7:0] xflag_d;
  reg [7:0] wdctrl_d;

  // =====================================================
  // apb decode
  wire       wrEn   = psel & penable & pwrite & pready;
  wire [7:0] wrByte = pwdata[7:0];
  wire       wrTc   = wrEn & (paddr == `FLIC_OFF_TCTRL);
  wire       wrXf   = wrEn & (paddr == `FLIC_OFF_XFLAG);
  wire       wrWd   = wrEn & (paddr == `FLIC_OFF_WDCTRL);
  wire       wrCfg  = wrEn & ((paddr == `FLIC_OFF_IEN) | (paddr == `FLIC_OFF_XEN) |
                              (paddr == `FLIC_OFF_PRIO_LO) | (paddr == `FLIC_OFF_PRIO_HI) |
                              (paddr == `FLIC_OFF_XPRIO_LO) | (paddr == `FLIC_OFF_XPRIO_HI));

  reg [31:0] rdMux;
  reg        rdErr;
  always @* begin
    rdErr = 1'b0;
    case (paddr)
      `FLIC_OFF_TCTRL:    rdMux = {24'h000000, tctrl_q};
      `FLIC_OFF_IEN:      rdMux = {24'h000000, ien_q};
      `FLIC_OFF_PRIO_LO:  rdMux = {24'h000000, prioLo_q};
      `FLIC_OFF_PRIO_HI:  rdMux = {24'h000000, prioHi_q};
      `FLIC_OFF_XFLAG:    rdMux = {24'h000000, xflag_q};
      `FLIC_OFF_XEN:      rdMux = {24'h000000, xen_q};
      `FLIC_OFF_XPRIO_LO: rdMux = {24'h000000, xprioLo_q};
      `FLIC_OFF_XPRIO_HI: rdMux = {24'h000000, xprioHi_q};
      `FLIC_OFF_WDCTRL:   rdMux = {24'h000000, wdctrl_q};
      `FLIC_OFF_STATUS:   rdMux = {16'h0000, irqVector, 3'h0, inService};
      `FLIC_OFF_CTRL:     rdMux = {24'h000000, ctrl_q};
      default: begin
        rdMux = 32'h00000000;
        rdErr = 1'b1;
      end
    endcase
  end

  // no wait state: data captured in setup, ready in first access cycle
  always @(posedge clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= (psel & ~penable & ~pwrite) ? rdMux : 32'h00000000;
      pslverr <= psel & ~penable & rdErr;
    end
  end

  // =====================================================
  // power management sample divider
  always @(posedge clk) begin
    if (sys_rst) begin
      divCnt_q   <= 10'h000;
      sampleEn_q <= 1'b0;
    end else if (ctrl_q[`FLIC_CTRL_PMM]) begin
      divCnt_q   <= divCnt_q + 10'h001;
      sampleEn_q <= (divCnt_q == `FLIC_PMM_DIV_M1); // RQ19
    end else begin
      divCnt_q   <= 10'h000;
      sampleEn_q <= 1'b1;
    end
  end

  // =====================================================
  // external pin sampling
  wire [5:0] pinAsync = {ext_pin_five, ext_pin_four, ext_pin_three,
                         ext_pin_two, ext_pin_one, ext_pin_zero};
  wire [5:0] pinLevel;
  wire [5:0] pinRise;
  wire [5:0] pinFall;
  localparam [5:0] PIN_IDLE = `FLIC_PIN_IDLE;

  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : gPin
      flic_edge_detect #(
        .IDLE (PIN_IDLE[g])
      ) uEdge (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .pinAsync (pinAsync[g]),
        .sampleEn (sampleEn_q),
        .pinLevel (pinLevel[g]),
        .riseEvt  (pinRise[g]),
        .fallEvt  (pinFall[g])
      );
    end
  endgenerate

  // ext2/4 rising, ext3/5 falling
  wire [3:0] xEdge = {pinFall[5], pinRise[4], pinFall[3], pinRise[2]}; // RQ17

  // =====================================================
  // request vector and levels
  wire [12:0] flagVec;
  wire [12:0] enVec;
  wire [12:0] hiBits = {xprioHi_q[4:0], prioHi_q[6:0], 1'b0};
  wire [12:0] loBits = {xprioLo_q[4:0], prioLo_q[6:0], 1'b0};
  wire [38:0] lvlFlat;
  wire        gEn = ien_q[`FLIC_IEN_GLOBAL];

  assign flagVec = {wdctrl_q[`FLIC_WD_WD_FLAG], xflag_q[7:4],
                    serial_one_rx_flag | serial_one_tx_flag, // RQ25
                    timer_two_overflow_flag | timer_two_external_flag,
                    serial_zero_rx_flag | serial_zero_tx_flag,
                    tctrl_q[`FLIC_TC_TF1], tctrl_q[`FLIC_TC_EXT1_FLAG],
                    tctrl_q[`FLIC_TC_TF0], tctrl_q[`FLIC_TC_EXT0_FLAG],
                    wdctrl_q[`FLIC_WD_PF_FLAG]};

  assign enVec = {{12{gEn}} & {xen_q[4:0], ien_q[6:0]}, // RQ8
                  wdctrl_q[`FLIC_WD_PF_EN]};            // RQ9

  generate
    for (g = 0; g < 13; g = g + 1) begin : gLvl
      if (g == 0) begin : gPf
        assign lvlFlat[2:0] = `FLIC_PF_LEVEL; // RQ1
      end else begin : gProg
        assign lvlFlat[3*g +: 3] = prioLevel(hiBits[g], loBits[g]); // RQ1
      end
    end
  endgenerate

  wire [12:0] reqVec = flagVec & enVec; // RQ4

  // =====================================================
  // arbitration
  reg [2:0] bestLvl;
  reg [3:0] bestIdx;
  reg       found;
  reg [2:0] svcLvl;
  reg       svcAny;
  always @* begin
    bestLvl = 3'd0;
    bestIdx = 4'd0;
    found   = 1'b0;
    // lower index scanned last so it wins ties
    for (i = 12; i >= 0; i = i - 1) begin
      if (reqVec[i] && (!found || lvlFlat[3*i +: 3] >= bestLvl)) begin // RQ3 RQ20
        bestLvl = lvlFlat[3*i +: 3];
        bestIdx = i[3:0];
        found   = 1'b1;
      end
    end
    svcLvl = 3'd0;
    svcAny = 1'b0;
    for (i = 0; i < 5; i = i + 1) begin
      if (inService[i]) begin
        svcLvl = i[2:0];
        svcAny = 1'b1;
      end
    end
  end

  wire preemptOk = ~svcAny | (bestLvl > svcLvl); // RQ11
  // a config write in the evaluation cycle itself also skips it
  wire evalNow   = lastCycle & ~skipSel_q & ~wrCfg & ~return_from_isr; // RQ12 RQ22
  wire takeIrq   = evalNow & found & preemptOk; // RQ21

  // =====================================================
  // call, vector and in-service tracking
  reg [4:0] svcClr;
  always @* begin
    svcClr = 5'h00;
    if (lastCycle & return_from_isr & svcAny) begin
      svcClr[svcLvl] = 1'b1; // RQ10
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      irqCall   <= 1'b0;
      irqVector <= 8'h00;
      inService <= 5'h00;
      skipSel_q <= 1'b0;
    end else begin
      irqCall <= takeIrq; // RQ21
      if (takeIrq) begin
        irqVector <= vecOf(bestIdx); // RQ2
      end
      inService <= (inService & ~svcClr) | ({4'h0, takeIrq} << bestLvl); // RQ10
      if (lastCycle) begin
        skipSel_q <= 1'b0;
      end else if (wrCfg) begin
        skipSel_q <= 1'b1; // RQ22
      end
    end
  end

  // =====================================================
  // flag updates: software write, vector clear, hardware set last
  wire ackT0 = takeIrq & (bestIdx == 4'd2);
  wire ackT1 = takeIrq & (bestIdx == 4'd4);
  wire ackX0 = takeIrq & (bestIdx == 4'd1);
  wire ackX1 = takeIrq & (bestIdx == 4'd3);

  always @* begin
    tctrl_d = tctrl_q;
    if (wrTc) begin
      tctrl_d = wrByte;
    end
    if (ackT0) begin
      tctrl_d[`FLIC_TC_TF0] = 1'b0; // RQ5
    end
    if (ackT1) begin
      tctrl_d[`FLIC_TC_TF1] = 1'b0; // RQ5
    end
    if (ackX0 & tctrl_q[`FLIC_TC_EXT0_EDGE]) begin
      tctrl_d[`FLIC_TC_EXT0_FLAG] = 1'b0; // RQ6
    end
    if (ackX1 & tctrl_q[`FLIC_TC_EXT1_EDGE]) begin
      tctrl_d[`FLIC_TC_EXT1_FLAG] = 1'b0; // RQ6
    end
    if (timerZeroOvf) begin
      tctrl_d[`FLIC_TC_TF0] = 1'b1; // RQ4 RQ23
    end
    if (timerOneOvf) begin
      tctrl_d[`FLIC_TC_TF1] = 1'b1; // RQ23
    end
    if (tctrl_q[`FLIC_TC_EXT0_EDGE]) begin
      if (pinFall[0]) begin
        tctrl_d[`FLIC_TC_EXT0_FLAG] = 1'b1; // RQ14 RQ23
      end
    end else begin
      tctrl_d[`FLIC_TC_EXT0_FLAG] = ~pinLevel[0]; // RQ6 RQ13 RQ16
    end
    if (tctrl_q[`FLIC_TC_EXT1_EDGE]) begin
      if (pinFall[1]) begin
        tctrl_d[`FLIC_TC_EXT1_FLAG] = 1'b1; // RQ14
      end
    end else begin
      tctrl_d[`FLIC_TC_EXT1_FLAG] = ~pinLevel[1]; // RQ13
    end
  end

  always @* begin
    xflag_d = xflag_q;
    if (wrXf) begin
      xflag_d[7:4] = wrByte[7:4]; // RQ7
    end
    xflag_d[7:4] = xflag_d[7:4] | xEdge; // RQ18 RQ23
    wdctrl_d = wdctrl_q;
    if (wrWd) begin
      wdctrl_d = wrByte;
    end
    if (pwrFailWarn) begin
      wdctrl_d[`FLIC_WD_PF_FLAG] = 1'b1; // RQ7 RQ23
    end
    if (watchdogIrqEvt) begin
      wdctrl_d[`FLIC_WD_WD_FLAG] = 1'b1; // RQ23
    end
  end

  // =====================================================
  // register storage
  always @(posedge clk) begin
    if (sys_rst) begin
      tctrl_q   <= `FLIC_RST_BYTE;
      ien_q     <= `FLIC_RST_BYTE;
      prioLo_q  <= `FLIC_RST_BYTE;
      prioHi_q  <= `FLIC_RST_BYTE;
      xflag_q   <= `FLIC_RST_BYTE;
      xen_q     <= `FLIC_RST_BYTE;
      xprioLo_q <= `FLIC_RST_BYTE;
      xprioHi_q <= `FLIC_RST_BYTE;
      wdctrl_q  <= `FLIC_RST_BYTE;
      ctrl_q    <= `FLIC_RST_BYTE;
    end else begin
      tctrl_q  <= tctrl_d;
      xflag_q  <= {xflag_d[7:4], 4'h0};
      wdctrl_q <= {2'b00, wdctrl_d[5:3], 3'b000};
      if (wrEn) begin
        case (paddr)
          `FLIC_OFF_IEN:      ien_q     <= wrByte;
          `FLIC_OFF_PRIO_LO:  prioLo_q  <= {1'b0, wrByte[6:0]};
          `FLIC_OFF_PRIO_HI:  prioHi_q  <= {1'b0, wrByte[6:0]};
          `FLIC_OFF_XEN:      xen_q     <= {3'b000, wrByte[4:0]};
          `FLIC_OFF_XPRIO_LO: xprioLo_q <= {3'b000, wrByte[4:0]};
          `FLIC_OFF_XPRIO_HI: xprioHi_q <= {3'b000, wrByte[4:0]};
          `FLIC_OFF_CTRL:     ctrl_q    <= {7'h00, wrByte[0]};
          default:            ctrl_q    <= ctrl_q;
        endcase
      end
    end
  end

endmodule

// ==== rtl/flic_defines.vh ====
`ifndef FLIC_DEFINES_VH
`define FLIC_DEFINES_VH

// register byte offsets on the APB
`define FLIC_OFF_TCTRL    8'h00
`define FLIC_OFF_IEN      8'h04
`define FLIC_OFF_PRIO_LO  8'h08
`define FLIC_OFF_PRIO_HI  8'h0c
`define FLIC_OFF_XFLAG    8'h10
`define FLIC_OFF_XEN      8'h14
`define FLIC_OFF_XPRIO_LO 8'h18
`define FLIC_OFF_XPRIO_HI 8'h1c
`define FLIC_OFF_WDCTRL   8'h20
`define FLIC_OFF_STATUS   8'h24
`define FLIC_OFF_CTRL     8'h28

// timer control register fields
`define FLIC_TC_TF1       7
`define FLIC_TC_TF0       5
`define FLIC_TC_EXT1_FLAG 3
`define FLIC_TC_EXT1_EDGE 2
`define FLIC_TC_EXT0_FLAG 1
`define FLIC_TC_EXT0_EDGE 0

// enable register global bit, watchdog control fields, control register PMM bit
`define FLIC_IEN_GLOBAL   7
`define FLIC_WD_PF_EN     5
`define FLIC_WD_PF_FLAG   4
`define FLIC_WD_WD_FLAG   3
`define FLIC_CTRL_PMM     0

// reset values
`define FLIC_RST_BYTE     8'h00

// vector addresses
`define FLIC_VEC_PF       8'h33
`define FLIC_VEC_EXT0     8'h03
`define FLIC_VEC_TMR0     8'h0b
`define FLIC_VEC_EXT1     8'h13
`define FLIC_VEC_TMR1     8'h1b
`define FLIC_VEC_SER0     8'h23
`define FLIC_VEC_TMR2     8'h2b
`define FLIC_VEC_SER1     8'h3b
`define FLIC_VEC_EXT2     8'h43
`define FLIC_VEC_EXT3     8'h4b
`define FLIC_VEC_EXT4     8'h53
`define FLIC_VEC_EXT5     8'h5b
`define FLIC_VEC_WDOG     8'h63

// levels, sources, timing
`define FLIC_PF_LEVEL     3'd4
`define FLIC_NUM_SRC      13
`define FLIC_PMM_DIV      1024
`define FLIC_PMM_DIV_M1   10'h3ff
// pin idle levels: ext0/1/3/5 idle high (falling active), ext2/4 idle low
`define FLIC_PIN_IDLE     6'b101011

`endif

// ==== rtl/flic_edge_detect.v ====
`timescale 1ns/100ps
module flic_edge_detect #(
  parameter IDLE = 1'b1
) (
  input  wire clk,
  input  wire sys_rst,
  input  wire pinAsync,
  input  wire sampleEn,
  output wire pinLevel,
  output wire riseEvt,
  output wire fallEvt
);

  reg sync1_q;
  reg sync2_q;
  reg sync3_q;
  reg stable_q;
  reg prev_q;

  // =====================================================
  // synchroniser and stable level
  always @(posedge clk) begin
    if (sys_rst) begin
      sync1_q  <= IDLE;
      sync2_q  <= IDLE;
      sync3_q  <= IDLE;
      stable_q <= IDLE;
      prev_q   <= IDLE;
    end else begin
      sync1_q <= pinAsync;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (sync2_q == sync3_q) begin
        stable_q <= sync3_q;
      end
      if (sampleEn) begin
        prev_q <= stable_q;
      end
    end
  end

  // =====================================================
  // edge seen between two successive samples
  assign pinLevel = stable_q;
  assign riseEvt  = sampleEn & stable_q & ~prev_q;
  assign fallEvt  = sampleEn & ~stable_q & prev_q;

endmodule

// ==== verif/flic_checker.sv ====
`timescale 1ns/100ps
// ====================================
// protocol and arbitration checks
module flic_checker (
  input logic       clk,
  input logic       sys_rst,
  input logic       psel,
  input logic       penable,
  input logic       pready,
  input logic       pslverr,
  input logic       lastCycle,
  input logic       return_from_isr,
  input logic       irqCall,
  input logic [7:0] irqVector,
  input logic [4:0] inService
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_call_needs_eval: assert property (irqCall |-> $past(lastCycle))
    else $error("call without evaluation cycle");
  a_call_one_pulse: assert property (irqCall && !lastCycle |=> !irqCall)
    else $error("call pulse longer than one cycle");
  a_ret_no_call: assert property (irqCall |-> !$past(return_from_isr))
    else $error("call selected during return");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_err_in_access: assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access cycle");
  a_vector_hold: assert property (!irqCall |-> $stable(irqVector))
    else $error("vector changed without call");
  a_service_hold: assert property (!$past(lastCycle) |-> $stable(inService))
    else $error("service level changed outside evaluation");
  a_call_marks: assert property (irqCall |-> inService != 5'h00)
    else $error("call without level in service");
  a_pf_top_level: assert property (irqCall && irqVector == 8'h33 |-> inService[4])
    else $error("power-fail not at level four");
  a_ret_clears: assert property (lastCycle && return_from_isr && inService[4] |=> !inService[4])
    else $error("return kept top level");
endmodule

bind flic_top flic_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .lastCycle(lastCycle), .return_from_isr(return_from_isr), .irqCall(irqCall), .irqVector(irqVector),
  .inService(inService)
);

// ==== verif/flic_cpu_model.sv ====
`timescale 1ns/100ps
// ====================================
// instruction sequencer of the core
module flic_cpu_model (
  input  logic clk,
  output logic lastCycle,
  output logic return_from_isr
);
  initial begin
    lastCycle = 1'b0;
    return_from_isr = 1'b0;
  end

  // one instruction of len cycles; only its final cycle is flagged
  task automatic run(input logic ret, input int len);
    repeat (len - 1) @(posedge clk);
    lastCycle <= 1'b1;
    return_from_isr <= ret;
    @(posedge clk);
    lastCycle <= 1'b0;
    return_from_isr <= 1'b0;
  endtask
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/100ps
`include "flic_defines.vh"
module tb_top;
  logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, useAlt = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, err, irqCall, lastCycle, return_from_isr;
  logic [7:0]  irqVector;
  logic [4:0]  inService;
  logic [12:0] lvl = 0;
  int          n_errors = 0, num_checks = 0, cyc = 0;
  logic [7:0]  vecs [13] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53,
                             8'h5b, 8'h63};
  wire  [5:0]  pins = `FLIC_PIN_IDLE ^ {lvl[11:8], lvl[3], lvl[1]};

  flic_top u_dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pin_zero(pins[0]),
    .ext_pin_one(pins[1]), .ext_pin_two(pins[2]), .ext_pin_three(pins[3]), .ext_pin_four(pins[4]),
    .ext_pin_five(pins[5]), .pwrFailWarn(lvl[0]), .timerZeroOvf(lvl[2]), .timerOneOvf(lvl[4]),
    .timer_two_overflow_flag(lvl[6] & !useAlt), .timer_two_external_flag(lvl[6] & useAlt),
    .serial_zero_rx_flag(lvl[5] & !useAlt), .serial_zero_tx_flag(lvl[5] & useAlt),
    .serial_one_rx_flag(lvl[7] & !useAlt), .serial_one_tx_flag(lvl[7] & useAlt),
    .watchdogIrqEvt(lvl[12]), .lastCycle(lastCycle), .return_from_isr(return_from_isr),
    .irqCall(irqCall), .irqVector(irqVector), .inService(inService)
  );
  flic_cpu_model u_cpu (.clk(clk), .lastCycle(lastCycle), .return_from_isr(return_from_isr));

  initial forever #2.5 clk = ~clk;

  // ====================================
  // shared tasks
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask

  // pins held active three cycles then idle eight, level sources kept until serviced
  task raise(input logic [12:0] m);
    lvl <= m;
    repeat (3) @(posedge clk);
    lvl <= m & 13'h0e0;
    repeat (8) @(posedge clk);
  endtask

  task step(input logic ret, input logic expCall, input logic [7:0] vec, input int len = 2);
    u_cpu.run(ret, len);
    // look at the next edge while the one-cycle pulse still stands
    @(posedge clk);
    chk(irqCall, expCall);
    if (expCall) chk(irqVector, vec);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      n_errors++;
      close_out();
    end
  end

  // ====================================
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 0;
    apb(0, `FLIC_OFF_IEN, 0); chk(rd, 0);
    apb(0, 8'h2c, 0); chk(err, 1); chk(rd, 0);
    apb(1, `FLIC_OFF_IEN, 32'hff); apb(1, `FLIC_OFF_XEN, 32'h1f);
    apb(1, `FLIC_OFF_WDCTRL, 32'h20); apb(1, `FLIC_OFF_TCTRL, 32'h05);
    step(0, 0, 0);
    for (int p = 0; p < 2; p++) begin
      useAlt <= p[0];
      for (int i = 0; i < 13; i++) begin
        raise(13'h1 << i);
        step(0, 1, vecs[i]);
        lvl <= 0;
        step(1, 0, 0);
        apb(0, `FLIC_OFF_TCTRL, 0); chk(rd, 32'h05);
        apb(0, `FLIC_OFF_STATUS, 0); chk(rd, {16'h0, vecs[i], 8'h00});
        apb(1, `FLIC_OFF_XFLAG, 0); apb(1, `FLIC_OFF_WDCTRL, 32'h20);
      end
    end
    $display("source table done");
    apb(1, `FLIC_OFF_IEN, 32'h7f); raise(13'h004); step(0, 0, 0);
    apb(0, `FLIC_OFF_TCTRL, 0); chk(rd, 32'h25);
    step(0, 0, 0);
    apb(1, `FLIC_OFF_IEN, 32'hff); step(0, 0, 0);
    step(0, 1, 8'h0b);
    raise(13'h010); step(0, 0, 0, 4);
    apb(1, `FLIC_OFF_IEN, 0); step(0, 0, 0);
    raise(13'h001); step(0, 1, 8'h33);
    chk(inService, 5'b10001);
    apb(1, `FLIC_OFF_WDCTRL, 32'h20);
    step(1, 0, 0); step(1, 0, 0); chk(inService, 0);
    $display("gating and nesting done");
    apb(1, `FLIC_OFF_PRIO_HI, 32'h02); apb(1, `FLIC_OFF_PRIO_LO, 32'h08); apb(1, `FLIC_OFF_IEN, 32'hff);
    raise(13'h034); step(0, 0, 0);
    step(0, 1, 8'h0b); chk(inService, 5'b00100);
    step(0, 0, 0, 4);
    step(1, 0, 0); step(0, 1, 8'h1b);
    step(1, 0, 0); step(0, 1, 8'h23);
    lvl <= 0;
    step(1, 0, 0);
    apb(1, `FLIC_OFF_PRIO_HI, 0); apb(1, `FLIC_OFF_PRIO_LO, 0);
    raise(13'h0c0); step(0, 0, 0);
    step(0, 1, 8'h2b);
    lvl <= 0;
    step(1, 0, 0);
    $display("levels and order done");
    apb(1, `FLIC_OFF_CTRL, 32'h01); lvl <= 13'h100;
    repeat (20) @(posedge clk);
    apb(0, `FLIC_OFF_XFLAG, 0); chk(rd, 32'h00);
    repeat (1100) @(posedge clk);
    apb(0, `FLIC_OFF_XFLAG, 0); chk(rd, 32'h10);
    lvl <= 0;
    apb(1, `FLIC_OFF_CTRL, 0); apb(1, `FLIC_OFF_XFLAG, 0);
    $display("power management done");
    raise(13'h001); step(0, 1, 8'h33);
    sys_rst <= 1;
    repeat (4) @(posedge clk);
    chk(irqCall, 0); chk(irqVector, 0); chk(inService, 0);
    sys_rst <= 0;
    apb(0, `FLIC_OFF_WDCTRL, 0); chk(rd, 0);
    apb(0, `FLIC_OFF_IEN, 0); chk(rd, 0);
    $display("mid-run reset done");
    close_out();
  end
endmodule
